// ==== verilog/apdu_parser.sv ====
`timescale 1ns/1ns
// ------------------------------------------------------------
// Command APDU interpreter, byte stream in and out
// ------------------------------------------------------------
module apdu_parser #(
    parameter int ADDR_W = 15,     // Byte address width from parameter bytes
    parameter int MEM_BYTES = 8192 // Size of addressable memory
) (
    input  wire logic        clk_i,           // System clock
    input  wire logic        rst_i,           // Asynchronous reset, high
    // Information field byte stream from block layer
    input  wire logic        inf_valid_i,     // Byte valid
    input  wire logic [7:0]  inf_byte_i,      // Byte value
    input  wire logic        inf_last_i,      // Last byte of field
    // Response byte stream to block layer
    output logic             rsp_valid_o,     // Response byte valid
    output logic [7:0]       rsp_byte_o,      // Response byte
    output logic             rsp_last_o,      // Last response byte
    input  wire logic        rsp_ready_i,     // Block layer takes byte
    // Data returned by memory or tunnel for reads
    input  wire logic        rd_valid_i,      // Read byte valid
    input  wire logic [7:0]  rd_byte_i,       // Read byte
    // Decoded access towards memory / tunnel
    output logic             access_o,        // One-cycle access start pulse
    output logic             access_write_o,  // Access is a write
    output logic             access_tunnel_o, // Encrypted tunnel access
    output logic [ADDR_W-1:0] access_addr_o,  // Start byte address
    output logic [7:0]       access_len_o,    // Byte count
    output logic             wr_valid_o,      // Write data byte valid
    output logic [7:0]       wr_byte_o,       // Write data byte
    // Request filter and identity
    input  wire logic        req_valid_i,     // Request command seen
    input  wire logic [7:0]  req_afi_i,       // Request family identifier
    input  wire logic [7:0]  stored_afi_i,    // Configured family identifier
    output logic             req_respond_o,   // Pulse: answer request
    input  wire logic [63:0] identification_memory_area_i, // Stored ID bytes
    output logic [31:0]      pupi_o,          // Pseudo-unique identifier
    input  wire logic [3:0]  fwi_cfg_i,       // Configured waiting integer
    output logic [7:0]       fwi_param_o      // Advertised parameter byte
);
    initial begin
        if (ADDR_W != 15 || MEM_BYTES < 1 || MEM_BYTES > (1 << ADDR_W))
            $error("apdu_parser: unsupported parameters");
    end

    // ------------------------------------------------------------
    // Header capture
    // ------------------------------------------------------------
    apdu_parser_pkg::parse_state_t state;   // Parser state
    logic [3:0]  pos;          // Byte position in field
    logic [7:0]  cla;          // Class byte
    logic [7:0]  ins;          // Instruction byte
    logic [7:0]  p1;           // First parameter byte
    logic [7:0]  p2;           // Second parameter byte
    logic [7:0]  len;          // Length or expected-length byte
    logic        len_seen;     // A length byte arrived
    logic        extra;        // Bytes after length (data present)
    logic [7:0]  data_cnt;     // Data bytes seen
    logic [15:0] sw;           // Status to send
    logic [7:0]  rsp_cnt;      // Response data bytes left
    logic        respond_q;    // Registered filter result

    // Decode of the captured header, all combinational
    wire logic [2:0] mode = p1[apdu_parser_pkg::MODE_HI:apdu_parser_pkg::MODE_LO]; // RULE_17
    wire logic top_set = p1[apdu_parser_pkg::P1_TOP_BIT];                       // RULE_15
    wire logic mode_bad = (mode != apdu_parser_pkg::MODE_DIRECT) &&
                          (mode != apdu_parser_pkg::MODE_TUNNEL);                 // RULE_18
    wire logic [ADDR_W-1:0] start_addr = {p1[3:0], p2, 3'h0} >> 3;              // RULE_19
    wire logic [ADDR_W:0] end_addr = {1'b0, start_addr} + {{(ADDR_W-7){1'b0}}, len};
    wire logic addr_bad = (mode == apdu_parser_pkg::MODE_DIRECT) &&
                          ({1'b0, end_addr} > (ADDR_W+2)'(MEM_BYTES));
    wire logic is_rd = (ins == apdu_parser_pkg::INS_READ);
    wire logic is_wr = (ins == apdu_parser_pkg::INS_WRITE);
    wire logic is_sel = (ins == apdu_parser_pkg::INS_SELECT);
    wire logic param_bad = top_set || mode_bad || addr_bad;                     // RULE_16
    wire logic len_bad = (is_wr && (!len_seen || !extra || data_cnt != len)) ||
                         (is_rd && (!len_seen || extra));
    // Status priority: class, instruction, parameters, lengths
    wire logic [15:0] eval_sw =
        (cla != apdu_parser_pkg::CLASS_OK) ? apdu_parser_pkg::SW_CLASS :        // RULE_04
        (is_sel)                           ? apdu_parser_pkg::SW_NORMAL :       // RULE_13
        (!(is_rd || is_wr))                ? apdu_parser_pkg::SW_INSTR :
        (param_bad)                        ? apdu_parser_pkg::SW_PARAM :        // RULE_16
        (len_bad)                          ? apdu_parser_pkg::SW_LENGTH :
                                             apdu_parser_pkg::SW_NORMAL;
    wire logic eval_ok = (eval_sw == apdu_parser_pkg::SW_NORMAL) && !is_sel;
    wire logic in_data = (pos > apdu_parser_pkg::POS_LEN) || (state == apdu_parser_pkg::ST_BODY &&
                          pos == apdu_parser_pkg::POS_LEN && len_seen);
    wire logic take = rsp_valid_o && rsp_ready_i;

    wire logic filter_hit;     // Family filter result
    family_filter u_filter (
        .request_afi_i (req_afi_i),
        .stored_afi_i  (stored_afi_i),
        .respond_o     (filter_hit)
    );

    // ------------------------------------------------------------
    // Identity and waiting-time parameter byte
    // ------------------------------------------------------------
    // Registered so every output comes from a flip-flop
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pupi_o        <= 32'h0;
            fwi_param_o   <= 8'h0;
            req_respond_o <= 1'b0;
            respond_q     <= 1'b0;
        end else begin
            pupi_o        <= identification_memory_area_i[31:0];            // RULE_10
            // Clamp out-of-range integers to the largest legal one
            fwi_param_o   <= {(fwi_cfg_i > apdu_parser_pkg::FWI_MAX) ?
                              apdu_parser_pkg::FWI_MAX : fwi_cfg_i, 4'h0};  // RULE_11 RULE_12
            req_respond_o <= req_valid_i && filter_hit;
            respond_q     <= filter_hit;
        end
    end

    // ------------------------------------------------------------
    // Command field walk and response sequencing
    // ------------------------------------------------------------
    // Bytes arrive only inside the information field
    always_ff @(posedge clk_i or posedge rst_i) begin                      // RULE_01
        if (rst_i) begin
            state <= apdu_parser_pkg::ST_IDLE;
            pos <= 4'h0;
            cla <= 8'h0;
            ins <= 8'h0;
            p1 <= 8'h0;
            p2 <= 8'h0;
            len <= 8'h0;
            len_seen <= 1'b0;
            extra <= 1'b0;
            data_cnt <= 8'h0;
            sw <= 16'h0;
            rsp_cnt <= 8'h0;
            rsp_valid_o <= 1'b0;
            rsp_byte_o <= 8'h0;
            rsp_last_o <= 1'b0;
            access_o <= 1'b0;
            access_write_o <= 1'b0;
            access_tunnel_o <= 1'b0;
            access_addr_o <= '0;
            access_len_o <= 8'h0;
            wr_valid_o <= 1'b0;
            wr_byte_o <= 8'h0;
        end else begin
            access_o <= 1'b0;
            wr_valid_o <= 1'b0;
            unique case (state)
                apdu_parser_pkg::ST_IDLE,
                apdu_parser_pkg::ST_HEAD,
                apdu_parser_pkg::ST_BODY: begin
                    if (inf_valid_i) begin
                        // Header bytes in fixed order, then length
                        unique case (pos)
                            apdu_parser_pkg::POS_CLASS:  cla <= inf_byte_i;   // RULE_02
                            apdu_parser_pkg::POS_INSTR:  ins <= inf_byte_i;
                            apdu_parser_pkg::POS_PARAM1: p1 <= inf_byte_i;
                            apdu_parser_pkg::POS_PARAM2: p2 <= inf_byte_i;
                            apdu_parser_pkg::POS_LEN: begin
                                len <= inf_byte_i;                           // RULE_03
                                len_seen <= 1'b1;
                            end
                            default: begin
                                extra <= 1'b1;
                                data_cnt <= data_cnt + 8'h1;
                            end
                        endcase
                        if (pos != 4'hf)
                            pos <= pos + 4'h1;
                        state <= inf_last_i ? apdu_parser_pkg::ST_EVAL :
                                 (pos < apdu_parser_pkg::POS_PARAM2) ?
                                 apdu_parser_pkg::ST_HEAD : apdu_parser_pkg::ST_BODY;
                    end
                end
                apdu_parser_pkg::ST_EVAL: begin
                    // Write data was forwarded as it arrived, before the check; this design holds
                    // no data buffer, so data bytes are counted and forwarded only
                    sw <= eval_sw;
                    access_o <= eval_ok;
                    access_write_o <= is_wr;
                    access_tunnel_o <= (mode == apdu_parser_pkg::MODE_TUNNEL);
                    access_addr_o <= start_addr;                            // RULE_14
                    access_len_o <= len;
                    rsp_cnt <= (eval_ok && is_rd) ? len : 8'h0;
                    state <= (eval_ok && is_rd && len != 8'h0) ?
                             apdu_parser_pkg::ST_DATA : apdu_parser_pkg::ST_SW1;
                    rsp_valid_o <= !(eval_ok && is_rd && len != 8'h0);
                    rsp_byte_o <= eval_sw[15:8];
                    rsp_last_o <= 1'b0;
                end
                apdu_parser_pkg::ST_DATA: begin
                    // Response data first, status words after
                    if (take) begin
                        rsp_valid_o <= 1'b0;
                        rsp_cnt <= rsp_cnt - 8'h1;
                        if (rsp_cnt == 8'h1) begin
                            state <= apdu_parser_pkg::ST_SW1;                 // RULE_05
                            rsp_valid_o <= 1'b1;
                            rsp_byte_o <= sw[15:8];
                        end
                    end else if (rd_valid_i && !rsp_valid_o) begin
                        rsp_valid_o <= 1'b1;
                        rsp_byte_o <= rd_byte_i;
                    end
                end
                apdu_parser_pkg::ST_SW1: begin
                    if (take) begin
                        rsp_byte_o <= sw[7:0];                               // RULE_05
                        rsp_last_o <= 1'b1;
                        state <= apdu_parser_pkg::ST_SW2;
                    end
                end
                apdu_parser_pkg::ST_SW2: begin
                    if (take) begin
                        rsp_valid_o <= 1'b0;
                        rsp_last_o <= 1'b0;
                        pos <= 4'h0;
                        len <= 8'h0;
                        len_seen <= 1'b0;
                        extra <= 1'b0;
                        data_cnt <= 8'h0;
                        state <= apdu_parser_pkg::ST_IDLE;
                    end
                end
                default: state <= apdu_parser_pkg::ST_IDLE;
            endcase
            // Forward write payload bytes as they arrive
            if (inf_valid_i && in_data && pos > apdu_parser_pkg::POS_LEN) begin
                wr_valid_o <= 1'b1;
                wr_byte_o <= inf_byte_i;
            end
        end
    end
endmodule : apdu_parser

// ==== verilog/apdu_parser_pkg.sv ====
// Functional notes
// RULE_01: APDUs travel only inside block information field
// RULE_02: Reader sends header, optional length and data
// RULE_03: Reader appends expected length when wanting data
// RULE_04: Nonzero class byte answers 0x6E 0x00
// RULE_05: Response is data then two status bytes
// RULE_06: Request family zero always draws a response
// RULE_07: Upper-nibble-only request matches stored upper nibble
// RULE_08: Lower-nibble-only request matches stored lower nibble
// RULE_09: Other request values need full byte match
// RULE_10: Card identifier is low four memory bytes
// RULE_11: Waiting-time integer limited to 0 through 14
// RULE_12: Waiting-time integer in upper nibble, rest zero
// RULE_13: File selection answers normal end, nothing else
// RULE_14: Read and write address from parameter bytes
// RULE_15: First parameter top bit set is an error
// RULE_16: Parameter errors answer 0x6A 0x86
// RULE_17: Mode zero direct access, 100b tunnel access
// RULE_18: Reserved mode values flagged as error
// RULE_19: Low parameter bits form byte start address
package apdu_parser_pkg;
    // ------------------------------------------------------------
    // Byte positions inside the information field
    // ------------------------------------------------------------
    localparam logic [3:0] POS_CLASS = 4'h0;
    localparam logic [3:0] POS_INSTR = 4'h1;
    localparam logic [3:0] POS_PARAM1 = 4'h2;
    localparam logic [3:0] POS_PARAM2 = 4'h3;
    localparam logic [3:0] POS_LEN = 4'h4;
    // ------------------------------------------------------------
    // Instruction codes and accepted class byte
    // ------------------------------------------------------------
    localparam logic [7:0] INS_SELECT = 8'ha4;
    localparam logic [7:0] INS_READ = 8'hb0;
    localparam logic [7:0] INS_WRITE = 8'hd6;
    localparam logic [7:0] CLASS_OK = 8'h00;
    // ------------------------------------------------------------
    // Status words
    // ------------------------------------------------------------
    localparam logic [15:0] SW_NORMAL = 16'h9000;
    localparam logic [15:0] SW_LENGTH = 16'h6700;
    localparam logic [15:0] SW_PARAM = 16'h6a86;
    localparam logic [15:0] SW_INSTR = 16'h6d00;
    localparam logic [15:0] SW_CLASS = 16'h6e00;
    // ------------------------------------------------------------
    // Parameter byte fields
    // ------------------------------------------------------------
    localparam int P1_TOP_BIT = 7;
    localparam int MODE_HI = 6;
    localparam int MODE_LO = 4;
    localparam logic [2:0] MODE_DIRECT = 3'h0;
    localparam logic [2:0] MODE_TUNNEL = 3'h4;
    localparam logic [3:0] FWI_MAX = 4'he;
    localparam logic [3:0] NIBBLE_ZERO = 4'h0;
    // ------------------------------------------------------------
    // Parser states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_HEAD = 3'b001,
        ST_BODY = 3'b011,
        ST_EVAL = 3'b010,
        ST_DATA = 3'b110,
        ST_SW1  = 3'b111,
        ST_SW2  = 3'b101
    } parse_state_t;
endpackage : apdu_parser_pkg

// ==== verilog/family_filter.sv ====
`timescale 1ns/1ns
// ------------------------------------------------------------
// Family identifier match for request commands
// ------------------------------------------------------------
module family_filter (
    input  wire logic [7:0] request_afi_i,  // Identifier carried by request
    input  wire logic [7:0] stored_afi_i,   // Configured identifier
    output logic            respond_o       // Device should answer
);
    wire logic up_zero = (request_afi_i[7:4] == apdu_parser_pkg::NIBBLE_ZERO);
    wire logic lo_zero = (request_afi_i[3:0] == apdu_parser_pkg::NIBBLE_ZERO);
    wire logic up_eq   = (request_afi_i[7:4] == stored_afi_i[7:4]);
    wire logic lo_eq   = (request_afi_i[3:0] == stored_afi_i[3:0]);
    // Priority: wildcard, then nibble forms, then full compare
    assign respond_o = (up_zero && lo_zero) ? 1'b1 :        // RULE_06
                       (lo_zero)            ? up_eq :       // RULE_07
                       (up_zero)            ? lo_eq :       // RULE_08
                       (request_afi_i == stored_afi_i);     // RULE_09
endmodule : family_filter

// ==== verification/apdu_parser_chk.sv ====
`timescale 1ns/1ns
// ------------------------------------------
// Port checks for the APDU interpreter
// ------------------------------------------
module apdu_parser_chk (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        rsp_valid_o,
    input wire logic [7:0]  rsp_byte_o,
    input wire logic        rsp_last_o,
    input wire logic        rsp_ready_i,
    input wire logic        access_o,
    input wire logic        access_tunnel_o,
    input wire logic        req_valid_i,
    input wire logic [7:0]  req_afi_i,
    input wire logic [7:0]  stored_afi_i,
    input wire logic        req_respond_o,
    input wire logic [63:0] identification_memory_area_i,
    input wire logic [31:0] pupi_o,
    input wire logic [3:0]  fwi_cfg_i,
    input wire logic [7:0]  fwi_param_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // Request filter: answer one cycle after the request
    AST_AFI_ZERO: assert property (req_valid_i && req_afi_i == 8'h00 |=> req_respond_o)
        else $error("Zero family unanswered");
    AST_AFI_HI: assert property (req_valid_i && req_afi_i[3:0] == 4'h0 && req_afi_i[7:4] != 4'h0
        |=> req_respond_o == $past(req_afi_i[7:4] == stored_afi_i[7:4]))
        else $error("Upper nibble answer wrong");
    AST_AFI_LO: assert property (req_valid_i && req_afi_i[7:4] == 4'h0 && req_afi_i[3:0] != 4'h0
        |=> req_respond_o == $past(req_afi_i[3:0] == stored_afi_i[3:0]))
        else $error("Lower nibble answer wrong");
    AST_AFI_FULL: assert property (req_valid_i && req_afi_i[7:4] != 4'h0 && req_afi_i[3:0] != 4'h0
        |=> req_respond_o == $past(req_afi_i == stored_afi_i))
        else $error("Full family answer wrong");
    // Registered views lag one cycle; skip the edge after reset
    AST_PUPI: assert property (!$past(rst_i) |-> pupi_o == $past(identification_memory_area_i[31:0]))
        else $error("Card identifier stale");
    AST_FWI_RANGE: assert property (!$past(rst_i)
        |-> fwi_param_o[7:4] == (($past(fwi_cfg_i) > 4'he) ? 4'he : $past(fwi_cfg_i)))
        else $error("Waiting integer wrong");
    AST_FWI_LOW: assert property (fwi_param_o[3:0] == 4'h0)
        else $error("Reserved waiting nibble not zero");
    // A response byte stands until taken; nothing follows the last for three cycles
    AST_RSP_HOLD: assert property (rsp_valid_o && !rsp_ready_i
        |=> rsp_valid_o && $stable(rsp_byte_o) && $stable(rsp_last_o))
        else $error("Response byte not held");
    AST_RSP_END: assert property (rsp_valid_o && rsp_ready_i && rsp_last_o |=> !rsp_valid_o [*3])
        else $error("Response runs past last byte");
    AST_ACC_PULSE: assert property (access_o |=> !access_o)
        else $error("Access start too long");
    COV_LAST: cover property (rsp_valid_o && rsp_ready_i && rsp_last_o);
    COV_TUNNEL: cover property (access_o && access_tunnel_o);
    COV_REQ: cover property (req_respond_o);
endmodule : apdu_parser_chk
bind apdu_parser apdu_parser_chk u_apdu_parser_chk (.*);

// ==== verification/reader_model.sv ====
`timescale 1ns/1ns
// ------------------------------------------
// Reader side: sends commands, takes answers, serves read bytes
// ------------------------------------------
module reader_model (
    input  wire logic        clk_i,
    output logic             inf_valid_o,
    output logic [7:0]       inf_byte_o,
    output logic             inf_last_o,
    input  wire logic        rsp_valid_i,
    input  wire logic [7:0]  rsp_byte_i,
    input  wire logic        rsp_last_i,
    output logic             rsp_ready_o,
    input  wire logic        access_i,
    input  wire logic        access_write_i,
    input  wire logic [14:0] access_addr_i,
    input  wire logic [7:0]  access_len_i,
    output logic             rd_valid_o,
    output logic [7:0]       rd_byte_o
);
    logic [7:0] rx [16];      // Collected answer bytes
    int         nr;           // Answer byte count
    logic       slow = 1'b0;  // Stall every other cycle when set
    int         left = 0;     // Read bytes still owed
    int         idx = 0;      // Next read byte offset
    logic       gave = 1'b0;  // A byte is out and not yet passed on
    logic       go;           // Offer a read byte this cycle
    initial begin
        inf_valid_o = 1'b0;
        inf_byte_o  = 8'h00;
        inf_last_o  = 1'b0;
        rsp_ready_o = 1'b0;
        rd_valid_o  = 1'b0;
        rd_byte_o   = 8'h00;
    end
    // Whole command inside one information field, header first
    task automatic exchange(input int n, input logic [127:0] cmd);
        logic done;
        nr = 0;
        done = 1'b0;
        for (int i = 0; i < n; i++) begin
            @(posedge clk_i);
            inf_valid_o <= 1'b1;
            inf_byte_o  <= cmd[127-8*i -: 8];
            inf_last_o  <= (i == n - 1);
        end
        @(posedge clk_i);
        inf_valid_o <= 1'b0;
        inf_last_o  <= 1'b0;
        inf_byte_o  <= ~cmd[127-8*(n-1) -: 8];  // Idle line never keeps the last byte
        for (int t = 0; t < 600 && !done; t++) begin
            @(posedge clk_i);
            if (rsp_valid_i && rsp_ready_o) begin
                rx[nr] = rsp_byte_i;
                nr++;
                done = rsp_last_i;
            end
            rsp_ready_o <= done ? 1'b0 : (slow ? ~rsp_ready_o : 1'b1);
        end
    endtask : exchange
    // One read byte at a time, only while no answer byte waits
    always @(posedge clk_i) begin
        go = !(access_i && !access_write_i) && left > 0 && !rsp_valid_i && !gave;
        rd_valid_o <= go;
        rd_byte_o  <= go ? access_addr_i[7:0] + idx[7:0] : ~rd_byte_o;
        if (go) begin
            idx++;
            left--;
            gave = 1'b1;
        end
        if (access_i && !access_write_i) begin
            left = access_len_i;
            idx = 0;
        end
        if (rsp_valid_i && rsp_ready_o) gave = 1'b0;
    end
endmodule : reader_model

// ==== verification/tb_apdu_parser.sv ====
`timescale 1ns/1ns
module tb_apdu_parser;
    localparam int MEM = 1024;  // Small memory so the range edge is reachable
    logic clk_i = 1'b0, rst_i = 1'b1, req_valid_i = 1'b0;
    logic [7:0] req_afi_i = 8'h00, stored_afi_i = 8'h00, wr_last = 8'h00;
    logic [63:0] idm_i = 64'h0;
    logic [3:0] fwi_cfg_i = 4'h0;
    logic inf_valid_i, inf_last_i, rsp_valid_o, rsp_last_o, rsp_ready_i, rd_valid_i;
    logic [7:0] inf_byte_i, rsp_byte_o, rd_byte_i, access_len_o, wr_byte_o, fwi_param_o;
    logic access_o, access_write_o, access_tunnel_o, wr_valid_o, req_respond_o;
    logic [14:0] access_addr_o;
    logic [31:0] pupi_o, seed = 32'h8126;
    int failures = 0, n_checks = 0, n_acc = 0, n_wr = 0, a0;
    always #5 clk_i = ~clk_i;
    apdu_parser #(.MEM_BYTES(MEM)) u_apdu_parser (.clk_i(clk_i), .rst_i(rst_i),
        .inf_valid_i(inf_valid_i), .inf_byte_i(inf_byte_i), .inf_last_i(inf_last_i),
        .rsp_valid_o(rsp_valid_o), .rsp_byte_o(rsp_byte_o), .rsp_last_o(rsp_last_o),
        .rsp_ready_i(rsp_ready_i), .rd_valid_i(rd_valid_i), .rd_byte_i(rd_byte_i),
        .access_o(access_o), .access_write_o(access_write_o), .access_tunnel_o(access_tunnel_o),
        .access_addr_o(access_addr_o), .access_len_o(access_len_o), .wr_valid_o(wr_valid_o),
        .wr_byte_o(wr_byte_o), .req_valid_i(req_valid_i), .req_afi_i(req_afi_i),
        .stored_afi_i(stored_afi_i), .req_respond_o(req_respond_o),
        .identification_memory_area_i(idm_i), .pupi_o(pupi_o), .fwi_cfg_i(fwi_cfg_i),
        .fwi_param_o(fwi_param_o));
    reader_model u_reader_model (.clk_i(clk_i), .inf_valid_o(inf_valid_i),
        .inf_byte_o(inf_byte_i), .inf_last_o(inf_last_i), .rsp_valid_i(rsp_valid_o),
        .rsp_byte_i(rsp_byte_o), .rsp_last_i(rsp_last_o), .rsp_ready_o(rsp_ready_i),
        .access_i(access_o), .access_write_i(access_write_o), .access_addr_i(access_addr_o),
        .access_len_i(access_len_o), .rd_valid_o(rd_valid_i), .rd_byte_o(rd_byte_i));
    // Count access starts and write bytes at the memory side
    always @(posedge clk_i) begin
        if (access_o) n_acc <= n_acc + 1;
        if (wr_valid_o) begin
            n_wr    <= n_wr + 1;
            wr_last <= wr_byte_o;
        end
    end
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        return x ^ (x << 5);
    endfunction : xs
    // Expected filter outcome, worked out from the family table
    function automatic logic afi_hit(input logic [7:0] r, input logic [7:0] s);
        if (r == 8'h00) return 1'b1;
        if (r[3:0] == 4'h0) return r[7:4] == s[7:4];
        if (r[7:4] == 4'h0) return r[3:0] == s[3:0];
        return r == s;
    endfunction : afi_hit
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // Send one command and compare the whole answer
    task automatic run(input int n, input logic [127:0] cmd, input int ne, input logic [127:0] e);
        u_reader_model.exchange(n, cmd);
        check(u_reader_model.nr, ne);
        for (int i = 0; i < ne; i++) check(u_reader_model.rx[i], e[127-8*i -: 8]);
    endtask : run
    // Two-byte read; the memory side returns the low address byte plus offset
    task automatic read_case(input logic [7:0] p1, input logic [7:0] p2);
        logic ok;
        ok = !p1[7] && (p1[6:4] == 3'h0 || p1[6:4] == 3'h4) && (p1[6] || {p1[3:0], p2} + 2 <= MEM);
        if (ok) run(5, {8'h00, 8'hb0, p1, p2, 8'h02, 88'h0}, 4, {p2, p2 + 8'h01, 16'h9000, 96'h0});
        else run(5, {8'h00, 8'hb0, p1, p2, 8'h02, 88'h0}, 2, {16'h6a86, 112'h0});
        if (ok) check({access_len_o, access_addr_o}, {8'h02, 3'h0, p1[3:0], p2});
        if (ok) check(access_tunnel_o, p1[6]);
    endtask : read_case
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : report_and_stop
    // Watchdog far past the expected run length
    initial begin
        #500000;
        failures++;
        report_and_stop();
    end
    initial begin
        logic [7:0] r, s;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        // Random filter, identity and waiting-time traffic with nibble corners
        for (int k = 0; k < 300; k++) begin
            seed = xs(seed);
            s = seed[7:0];
            r = seed[12] ? seed[23:16] : s & {{4{seed[8]}}, {4{seed[9]}}};
            @(posedge clk_i);
            req_valid_i  <= 1'b1;
            req_afi_i    <= r;
            stored_afi_i <= s;
            fwi_cfg_i    <= seed[27:24];
            idm_i        <= {seed, xs(seed)};
            @(posedge clk_i);
            req_valid_i <= 1'b0;
            @(negedge clk_i);
            check(req_respond_o, afi_hit(r, s));
            check(pupi_o, idm_i[31:0]);
            check(fwi_param_o, {(fwi_cfg_i > 4'he) ? 4'he : fwi_cfg_i, 4'h0});
        end
        $display("test filter done");
        // Every mode value; stalling reader for the upper half
        for (int m = 0; m < 8; m++) begin
            u_reader_model.slow = 1'(m / 4);
            read_case({1'b0, 3'(m), 4'h1}, 8'h23);
        end
        read_case(8'h81, 8'h23);
        read_case(8'h03, 8'hfe);
        read_case(8'h03, 8'hff);
        read_case(8'h4f, 8'hff);
        $display("test modes done");
        run(5, {8'h01, 8'hb0, 8'h00, 8'h10, 8'h02, 88'h0}, 2, {16'h6e00, 112'h0});
        run(5, {8'h80, 8'ha4, 8'h04, 8'h00, 8'h00, 88'h0}, 2, {16'h6e00, 112'h0});
        run(5, {8'h00, 8'h12, 8'h00, 8'h10, 8'h02, 88'h0}, 2, {16'h6d00, 112'h0});
        a0 = n_acc;
        run(5, {8'h00, 8'ha4, 8'h04, 8'h00, 8'h00, 88'h0}, 2, {16'h9000, 112'h0});
        check(n_acc - a0, 0);
        a0 = n_wr;
        run(8, {8'h00, 8'hd6, 8'h00, 8'h10, 8'h03, 24'haabbcc, 64'h0}, 2, {16'h9000, 112'h0});
        check(n_wr - a0, 3);
        check(wr_last, 8'hcc);
        check({access_write_o, access_addr_o}, {1'b1, 15'h0010});
        run(7, {8'h00, 8'hd6, 8'h00, 8'h10, 8'h03, 16'haabb, 72'h0}, 2, {16'h6700, 112'h0});
        $display("test commands done");
        report_and_stop();
    end
endmodule : tb_apdu_parser
